//--- ivc_ctrl.sv
/*
 * Interrupt vector controller: 20 flagged sources, masks, request line,
 * acknowledge cycle and vector output on a slave register port.
 * Assumes host pins arrive asynchronously and source events are one-cycle
 * pulses from logic on core_clk_in.
 */
// Contract
// - Twenty status flags, three status, three enables
// - Enabled active flag asserts low request output
// - Acknowledge input starts cycle, vector per control
// - Two-bit field selects none, single, double
// - No-acknowledge style never drives a vector
// - Single style drives vector on first acknowledge
// - Double style drives vector on second acknowledge
// - Select bit picks plain or modified vector
// - Plain vector output exactly as written
// - Modified vector: top two writable, six hardware
// - Six-bit code names highest-priority active source
// - Swap bit exchanges serial and DMA priority
// - Reset low six clocks resets this block
// - Seven low address lines select registers
`timescale 1ns/1ps
module ivc_ctrl (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [ivc_pkg::SRC_N-1:0] src_evt_in,
	input wire logic cs_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic irq_ack_n_in,
	input wire logic [ivc_pkg::ADDR_W-1:0] low_addr_lines_in,
	input wire logic [ivc_pkg::DATA_W-1:0] data_in,
	output logic [ivc_pkg::DATA_W-1:0] data_out,
	output logic data_oe_n_out,
	output logic irq_n_out
);

	ivc_pkg::ivc_pins_t pins_raw, sync1_r, sync2_r, prev_r;
	logic [ivc_pkg::SRC_N-1:0] status_r, status_nxt;
	logic [ivc_pkg::SRC_N-1:0] enable_r, enable_nxt;
	ivc_pkg::ivc_ctl_t ctl_r, ctl_nxt;
	logic [7:0] plain_vector_r, plain_vector_nxt;
	logic [1:0] mvec_top_r, mvec_top_nxt;
	logic ack_seen_r, ack_seen_nxt;
	logic [7:0] data_out_r, data_out_nxt;
	logic data_oe_n_r, data_oe_n_nxt;
	logic irq_n_r, irq_n_nxt;
	logic ser_hit, dma_hit, tmr_hit;
	logic [5:0] ser_idx, dma_idx, tmr_idx;
	logic [5:0] src_code;
	logic [7:0] modified_vector;
	logic [7:0] rd_data;
	logic [ivc_pkg::SRC_N-1:0] pending;
	logic wr_edge, ack_edge, reading, acking;

	assign pins_raw = '{cs_n: cs_n_in, rd_n: rd_n_in, wr_n: wr_n_in, ack_n: irq_ack_n_in,
		addr: low_addr_lines_in, data: data_in};

	// Every host pin passes two flops; the third stage feeds edge detection and the acknowledge hold.
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			sync1_r <= '1;
			sync2_r <= '1;
			prev_r <= '1;
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	assign pending = status_r & enable_r;
	assign wr_edge = !sync2_r.cs_n && !sync2_r.wr_n && prev_r.wr_n;
	assign ack_edge = !sync2_r.ack_n && prev_r.ack_n;
	assign reading = !sync2_r.cs_n && !sync2_r.rd_n;

	ivc_prio_enc #(.WIDTH(ivc_pkg::SER_N)) u_ser_enc (
		.req_in(pending[ivc_pkg::SER_BASE +: ivc_pkg::SER_N]),
		.hit_out(ser_hit),
		.idx_out(ser_idx)
	);
	ivc_prio_enc #(.WIDTH(ivc_pkg::DMA_N)) u_dma_enc (
		.req_in(pending[ivc_pkg::DMA_BASE +: ivc_pkg::DMA_N]),
		.hit_out(dma_hit),
		.idx_out(dma_idx)
	);
	ivc_prio_enc #(.WIDTH(ivc_pkg::TMR_N)) u_tmr_enc (
		.req_in(pending[ivc_pkg::TMR_BASE +: ivc_pkg::TMR_N]),
		.hit_out(tmr_hit),
		.idx_out(tmr_idx)
	);

	// The code is the source number; timers always rank below both other groups.
	always_comb begin
		src_code = ivc_pkg::CODE_NONE;
		if (tmr_hit) begin
			src_code = tmr_idx + 6'(ivc_pkg::TMR_BASE);
		end
		if (ctl_r.group_swap) begin
			if (ser_hit) begin
				src_code = ser_idx + 6'(ivc_pkg::SER_BASE);
			end
			if (dma_hit) begin
				src_code = dma_idx + 6'(ivc_pkg::DMA_BASE);
			end
		end else begin
			if (dma_hit) begin
				src_code = dma_idx + 6'(ivc_pkg::DMA_BASE);
			end
			if (ser_hit) begin
				src_code = ser_idx + 6'(ivc_pkg::SER_BASE);
			end
		end
	end

	assign modified_vector = {mvec_top_r, src_code};

	always_comb begin
		case (sync2_r.addr)
			ivc_pkg::ADDR_STATUS_0: rd_data = status_r[ivc_pkg::SER_BASE +: 8];
			ivc_pkg::ADDR_STATUS_1: rd_data = status_r[ivc_pkg::DMA_BASE +: 8];
			ivc_pkg::ADDR_STATUS_2: rd_data = {4'h0, status_r[ivc_pkg::TMR_BASE +: 4]};
			ivc_pkg::ADDR_ENABLE_0: rd_data = enable_r[ivc_pkg::SER_BASE +: 8];
			ivc_pkg::ADDR_ENABLE_1: rd_data = enable_r[ivc_pkg::DMA_BASE +: 8];
			ivc_pkg::ADDR_ENABLE_2: rd_data = {4'h0, enable_r[ivc_pkg::TMR_BASE +: 4]};
			ivc_pkg::ADDR_IRQ_CONTROL: rd_data = {4'h0, ctl_r};
			ivc_pkg::ADDR_PLAIN_VECTOR: rd_data = plain_vector_r;
			ivc_pkg::ADDR_MODIFIED_VECTOR: rd_data = modified_vector;
			default: rd_data = 8'h00;
		endcase
	end

	// Register writes, flag capture and clears. Status is write-one-to-clear.
	always_comb begin
		status_nxt = status_r;
		enable_nxt = enable_r;
		ctl_nxt = ctl_r;
		plain_vector_nxt = plain_vector_r;
		mvec_top_nxt = mvec_top_r;
		if (wr_edge) begin
			case (sync2_r.addr)
				ivc_pkg::ADDR_STATUS_0: status_nxt[ivc_pkg::SER_BASE +: 8] = status_r[ivc_pkg::SER_BASE +: 8]
					& ~sync2_r.data;
				ivc_pkg::ADDR_STATUS_1: status_nxt[ivc_pkg::DMA_BASE +: 8] = status_r[ivc_pkg::DMA_BASE +: 8]
					& ~sync2_r.data;
				ivc_pkg::ADDR_STATUS_2: status_nxt[ivc_pkg::TMR_BASE +: 4] = status_r[ivc_pkg::TMR_BASE +: 4]
					& ~sync2_r.data[3:0];
				ivc_pkg::ADDR_ENABLE_0: enable_nxt[ivc_pkg::SER_BASE +: 8] = sync2_r.data;
				ivc_pkg::ADDR_ENABLE_1: enable_nxt[ivc_pkg::DMA_BASE +: 8] = sync2_r.data;
				ivc_pkg::ADDR_ENABLE_2: enable_nxt[ivc_pkg::TMR_BASE +: 4] = sync2_r.data[3:0];
				ivc_pkg::ADDR_IRQ_CONTROL: ctl_nxt = ivc_pkg::ivc_ctl_t'(sync2_r.data[3:0]);
				ivc_pkg::ADDR_PLAIN_VECTOR: plain_vector_nxt = sync2_r.data;
				ivc_pkg::ADDR_MODIFIED_VECTOR: mvec_top_nxt = sync2_r.data[7:6];
				default: ;
			endcase
		end
		// A new event beats a clear in the same cycle.
		status_nxt = status_nxt | src_evt_in;
	end

	// Acknowledge cycle and data bus drive.
	always_comb begin
		ack_seen_nxt = ack_seen_r;
		data_out_nxt = data_out_r;
		data_oe_n_nxt = 1'b1;
		acking = 1'b0;
		irq_n_nxt = ~(|pending);
		if (irq_n_r) begin
			ack_seen_nxt = 1'b0;
		end
		if (!sync2_r.ack_n && !data_oe_n_r && !prev_r.ack_n) begin
			acking = 1'b1;
		end
		if (ack_edge && !irq_n_r) begin
			case (ctl_r.ack_style)
				ivc_pkg::ACK_SINGLE: acking = 1'b1;
				ivc_pkg::ACK_DOUBLE: begin
					acking = ack_seen_r;
					ack_seen_nxt = ~ack_seen_r;
				end
				default: acking = 1'b0;
			endcase
			data_out_nxt = ctl_r.vec_sel ? modified_vector : plain_vector_r;
		end
		if (acking) begin
			data_oe_n_nxt = 1'b0;
		end else if (reading) begin
			data_out_nxt = rd_data;
			data_oe_n_nxt = 1'b0;
		end
	end

	// A synchronous reset of any length clears the block; the six-clock minimum is the host's duty.
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			status_r <= '0;
			enable_r <= '0;
			ctl_r <= '0;
			plain_vector_r <= ivc_pkg::RST_BYTE;
			mvec_top_r <= 2'h0;
			ack_seen_r <= 1'b0;
			data_out_r <= ivc_pkg::RST_BYTE;
			data_oe_n_r <= 1'b1;
			irq_n_r <= 1'b1;
		end else begin
			status_r <= status_nxt;
			enable_r <= enable_nxt;
			ctl_r <= ctl_nxt;
			plain_vector_r <= plain_vector_nxt;
			mvec_top_r <= mvec_top_nxt;
			ack_seen_r <= ack_seen_nxt;
			data_out_r <= data_out_nxt;
			data_oe_n_r <= data_oe_n_nxt;
			irq_n_r <= irq_n_nxt;
		end
	end

	assign data_out = data_out_r;
	assign data_oe_n_out = data_oe_n_r;
	assign irq_n_out = irq_n_r;

endmodule : ivc_ctrl

//--- ivc_pkg.sv
/*
 * Shared constants and types of the interrupt vector controller.
 * Assumes a single 125 MHz core clock and a synchronous active-low reset.
 */
package ivc_pkg;

	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned SRC_N = 20;
	localparam int unsigned SER_N = 8;
	localparam int unsigned DMA_N = 8;
	localparam int unsigned TMR_N = 4;
	localparam int unsigned SER_BASE = 0;
	localparam int unsigned DMA_BASE = 8;
	localparam int unsigned TMR_BASE = 16;
	localparam int unsigned CODE_W = 6;

	localparam logic [6:0] ADDR_STATUS_0 = 7'h10;
	localparam logic [6:0] ADDR_STATUS_1 = 7'h11;
	localparam logic [6:0] ADDR_STATUS_2 = 7'h12;
	localparam logic [6:0] ADDR_ENABLE_0 = 7'h14;
	localparam logic [6:0] ADDR_ENABLE_1 = 7'h15;
	localparam logic [6:0] ADDR_ENABLE_2 = 7'h16;
	localparam logic [6:0] ADDR_IRQ_CONTROL = 7'h18;
	localparam logic [6:0] ADDR_PLAIN_VECTOR = 7'h1a;
	localparam logic [6:0] ADDR_MODIFIED_VECTOR = 7'h1b;

	localparam int unsigned CTL_ACK_LSB = 0;
	localparam int unsigned CTL_VSEL_BIT = 2;
	localparam int unsigned CTL_SWAP_BIT = 3;
	localparam logic [7:0] CTL_WR_MASK = 8'h0f;
	localparam logic [7:0] MVEC_SW_MASK = 8'hc0;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [5:0] CODE_NONE = 6'h3f;

	localparam logic [1:0] ACK_NONE = 2'h0;
	localparam logic [1:0] ACK_SINGLE = 2'h1;
	localparam logic [1:0] ACK_DOUBLE = 2'h2;

	localparam int unsigned RESET_MIN_NS = 48;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned RESET_MIN_CYC = 6;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic ack_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ivc_pins_t;

	typedef struct packed {
		logic group_swap;
		logic vec_sel;
		logic [1:0] ack_style;
	} ivc_ctl_t;

endpackage : ivc_pkg

//--- ivc_prio_enc.sv
/*
 * Fixed-priority encoder: lowest set bit wins, result is its index.
 * Assumes a combinational consumer in the same clock domain.
 */
`timescale 1ns/1ps
module ivc_prio_enc #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic [WIDTH-1:0] req_in,
	output logic hit_out,
	output logic [5:0] idx_out
);

	always_comb begin
		hit_out = 1'b0;
		idx_out = 6'h00;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (req_in[i]) begin
				hit_out = 1'b1;
				idx_out = 6'(i);
			end
		end
	end

endmodule : ivc_prio_enc

//--- ivc_ctrl_sva.sv
/* Port checker for the interrupt vector controller.
 * Assumes one core clock and the synchronous active-low reset. */
`timescale 1ns/1ps
module ivc_ctrl_sva (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [ivc_pkg::SRC_N-1:0] src_evt_in,
	input wire logic cs_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic irq_ack_n_in,
	input wire logic [ivc_pkg::DATA_W-1:0] data_out,
	input wire logic data_oe_n_out,
	input wire logic irq_n_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	logic req_w;
	// Pins are synchronised, so a drive may trail its cause by two or three edges.
	assign req_w = (!rd_n_in && !cs_n_in) || !irq_ack_n_in;
	sequence s_rd_quiet; (rd_n_in && irq_ack_n_in)[*3]; endsequence
	sequence s_cs_quiet; (cs_n_in && irq_ack_n_in)[*3]; endsequence
	a_reset_idle: assert property ($rose(nrst_in) |-> irq_n_out && data_oe_n_out && data_out == 8'h00)
		else $error("outputs not idle after reset");
	a_drive_cause: assert property (!data_oe_n_out |-> $past(req_w, 2) || $past(req_w, 3))
		else $error("bus driven without read or acknowledge");
	a_rd_release: assert property (s_rd_quiet |=> data_oe_n_out)
		else $error("bus still driven after strobes rose");
	a_cs_release: assert property (s_cs_quiet |=> data_oe_n_out)
		else $error("bus driven while not selected");
	// The host holds acknowledge for five sampled edges, so a longer window would never open.
	a_vec_hold: assert property (!irq_ack_n_in[*5] |-> $stable(data_out))
		else $error("vector changed during acknowledge");
	a_idle_ack: assert property ((irq_n_out && rd_n_in)[*4] |=> data_oe_n_out)
		else $error("vector driven with no request pending");
	a_irq_quiet: assert property ((irq_n_out && !(|src_evt_in) && wr_n_in)[*6] |=> irq_n_out)
		else $error("request raised without a source");
	a_irq_hold: assert property ((!irq_n_out && wr_n_in)[*6] |=> !irq_n_out)
		else $error("request dropped without clear or mask");
endmodule : ivc_ctrl_sva
bind ivc_ctrl ivc_ctrl_sva i_ivc_ctrl_sva (.core_clk_in, .nrst_in, .src_evt_in, .cs_n_in, .rd_n_in,
	.wr_n_in, .irq_ack_n_in, .data_out, .data_oe_n_out, .irq_n_out);

//--- ivc_host.sv
/* Host processor model: register writes, reads and acknowledges.
 * Assumes the device runs on the same core clock as this model. */
`timescale 1ns/1ps
module ivc_host (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	input wire logic oe_n_in,
	output ivc_pkg::ivc_pins_t pins_out
);
	initial pins_out = {4'hf, 7'h00, 8'h00};
	// Address is set up three edges early because the device synchronises its strobes.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_in);
		pins_out.addr <= a;
		pins_out.data <= d;
		repeat (3) @(posedge clk_in);
		{pins_out.cs_n, pins_out.wr_n} <= 2'h0;
		repeat (4) @(posedge clk_in);
		{pins_out.cs_n, pins_out.wr_n} <= 2'h3;
		pins_out.data <= ~d;
		repeat (2) @(posedge clk_in);
	endtask : wr
	task automatic xfer(input logic [6:0] a, input logic ack, output logic oe_n, output logic [7:0] d);
		@(posedge clk_in);
		pins_out.addr <= a;
		repeat (3) @(posedge clk_in);
		pins_out.ack_n <= !ack;
		{pins_out.cs_n, pins_out.rd_n} <= {ack, ack};
		repeat (4) @(posedge clk_in);
		#1;
		oe_n = oe_n_in;
		d = rdata_in;
		@(posedge clk_in);
		{pins_out.cs_n, pins_out.rd_n, pins_out.ack_n} <= 3'h7;
		repeat (4) @(posedge clk_in);
	endtask : xfer
endmodule : ivc_host

//--- test_interrupt_vector_controller.sv
/* Self-checking testbench of the interrupt vector controller.
 * Assumes the host model and the checker are compiled before it. */
`timescale 1ns/1ps
module test_interrupt_vector_controller;
	typedef struct {logic [7:0] ctl; logic [19:0] src; logic [1:0] oe; logic [7:0] vec;} ivc_row_t;
	logic core_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [19:0] src_evt_in = 20'h00000;
	ivc_pkg::ivc_pins_t pins;
	logic [7:0] data_out;
	logic [7:0] d;
	logic data_oe_n_out;
	logic irq_n_out;
	logic oe;
	int n_mismatch = 0;
	int n_compared = 0;
	ivc_row_t rows [7] = '{'{8'h00, 20'h00008, 2'h3, 8'h00}, '{8'h03, 20'h00008, 2'h3, 8'h00},
		'{8'h01, 20'h00008, 2'h0, 8'ha5}, '{8'h05, 20'h00200, 2'h0, 8'h89}, '{8'h06, 20'h20000, 2'h1, 8'h91},
		'{8'h05, 20'h00404, 2'h0, 8'h82}, '{8'h0d, 20'h00404, 2'h0, 8'h8a}};
	always #4 core_clk_in = ~core_clk_in;
	ivc_host i_ivc_host (.clk_in(core_clk_in), .rdata_in(data_out), .oe_n_in(data_oe_n_out), .pins_out(pins));
	ivc_ctrl i_ivc_ctrl (.core_clk_in, .nrst_in, .src_evt_in, .cs_n_in(pins.cs_n), .rd_n_in(pins.rd_n),
		.wr_n_in(pins.wr_n), .irq_ack_n_in(pins.ack_n), .low_addr_lines_in(pins.addr), .data_in(pins.data),
		.data_out, .data_oe_n_out, .irq_n_out);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic pulse(input logic [19:0] s);
		@(posedge core_clk_in);
		src_evt_in <= s;
		@(posedge core_clk_in);
		src_evt_in <= 20'h00000;
		repeat (3) @(posedge core_clk_in);
		#1;
	endtask : pulse
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge core_clk_in);
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		i_ivc_host.wr(ivc_pkg::ADDR_PLAIN_VECTOR, 8'ha5);
		i_ivc_host.wr(ivc_pkg::ADDR_MODIFIED_VECTOR, 8'hbf);
		i_ivc_host.wr(ivc_pkg::ADDR_ENABLE_0, 8'hff);
		i_ivc_host.wr(ivc_pkg::ADDR_ENABLE_1, 8'hff);
		i_ivc_host.wr(ivc_pkg::ADDR_ENABLE_2, 8'h0f);
		foreach (rows[i]) begin
			i_ivc_host.wr(ivc_pkg::ADDR_IRQ_CONTROL, rows[i].ctl);
			pulse(rows[i].src);
			chk({7'h00, irq_n_out}, 8'h00);
			for (int k = 0; k < 2; k++) begin
				i_ivc_host.xfer(7'h00, 1'b1, oe, d);
				chk({7'h00, oe}, {7'h00, rows[i].oe[k]});
				if (oe === 1'b0) chk(d, rows[i].vec);
			end
			i_ivc_host.wr(ivc_pkg::ADDR_STATUS_0, 8'hff);
			i_ivc_host.wr(ivc_pkg::ADDR_STATUS_1, 8'hff);
			i_ivc_host.wr(ivc_pkg::ADDR_STATUS_2, 8'hff);
			#1 chk({7'h00, irq_n_out}, 8'h01);
			$display("row %0d done", i);
		end
		i_ivc_host.wr(ivc_pkg::ADDR_ENABLE_0, 8'h00);
		pulse(20'h00001);
		chk({7'h00, irq_n_out}, 8'h01);
		i_ivc_host.xfer(7'h00, 1'b1, oe, d);
		chk({7'h00, oe}, 8'h01);
		i_ivc_host.xfer(ivc_pkg::ADDR_STATUS_0, 1'b0, oe, d);
		chk(d, 8'h01);
		i_ivc_host.wr(ivc_pkg::ADDR_ENABLE_0, 8'h01);
		#1 chk({7'h00, irq_n_out}, 8'h00);
		@(posedge core_clk_in);
		nrst_in <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		#1 chk({7'h00, irq_n_out}, 8'h01);
		chk({7'h00, data_oe_n_out}, 8'h01);
		i_ivc_host.xfer(ivc_pkg::ADDR_ENABLE_0, 1'b0, oe, d);
		chk(d, 8'h00);
		i_ivc_host.xfer(7'h7f, 1'b0, oe, d);
		chk(d, 8'h00);
		i_ivc_host.xfer(ivc_pkg::ADDR_MODIFIED_VECTOR, 1'b0, oe, d);
		chk(d, {2'h0, ivc_pkg::CODE_NONE});
		$display("mask, refusal and reset cases done");
		finish_test();
	end
endmodule : test_interrupt_vector_controller
